//--- usfb_pkg.sv
package usfb_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int         ADR_W       = 3;
  localparam logic [2:0] ADR_DATA    = 3'h0;
  localparam logic [2:0] ADR_STATUS  = 3'h1;
  localparam logic [2:0] ADR_CTRL    = 3'h2;
  localparam logic [2:0] ADR_FRAME   = 3'h3;
  localparam logic [2:0] ADR_BAUD_LO = 3'h4;
  localparam logic [2:0] ADR_BAUD_HI = 3'h5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] STATUS_RST  = 8'h20;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] FRAME_RST   = 8'h06;
  localparam logic [7:0] BAUD_RST    = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ST_RXC    = 7;
  localparam int ST_TXC    = 6;
  localparam int CT_RXEN   = 4;
  localparam int CT_TXEN   = 3;
  localparam int CT_DBL    = 2;
  localparam int CT_FILTER = 1;
  localparam int CT_TX9    = 0;
  localparam int FR_PODD   = 4;
  localparam int FR_PEN    = 5;
  localparam int FR_STOP2  = 3;
  localparam int FR_ORDER  = 2;
  localparam int FR_PHASE  = 1;

  // ****************************************
  // mode codes
  // ****************************************
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC  = 2'h1;
  localparam logic [1:0] MODE_IRDA  = 2'h2;
  localparam logic [1:0] MODE_SPIM  = 2'h3;
  localparam logic [2:0] CHSIZE_9   = 3'h7;

  // ****************************************
  // sampling counts
  // ****************************************
  localparam logic [4:0] SPB_NORMAL  = 5'h10;
  localparam logic [4:0] SPB_DOUBLE  = 5'h08;
  localparam logic [4:0] VOTE_NORMAL = 5'h0A;
  localparam logic [4:0] VOTE_DOUBLE = 5'h06;
  localparam logic [3:0] SPI_BITS    = 4'h8;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} usfb_rx_state_t;

  function automatic logic [3:0] usfb_nbits(input logic [2:0] cs);
    usfb_nbits = (cs == CHSIZE_9) ? 4'h9 : 4'({1'b0, cs} + 4'h5);
  endfunction

endpackage

//--- usfb_baud.sv
`timescale 1ns/100ps
module usfb_baud #(
  parameter int BW = 12
) (
  input  wire logic          ref_clk_i,
  input  wire logic          nrst_i,
  input  wire logic [BW-1:0] baud_select_value_i,
  input  wire logic [3:0]    baud_scale_exponent_i,
  output logic               tick_o
);
  import usfb_pkg::*;

  logic [BW:0] cnt_q;
  logic [7:0]  per_q;
  logic        tick_q;
  logic        neg;
  logic [3:0]  nabs;
  logic [7:0]  wrap_at;
  logic        wrap;

  assign neg     = baud_scale_exponent_i[3];
  assign nabs    = 4'(~baud_scale_exponent_i + 4'h1);
  assign wrap_at = neg ? 8'((9'h001 << nabs) - 9'h001)
                       : 8'((9'h001 << baud_scale_exponent_i[2:0]) - 9'h001);
  assign wrap    = (per_q == wrap_at);

  // ****************************************
  // down-counter with fractional stretch
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q  <= '0;
      per_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q  <= {1'b0, baud_select_value_i} + (BW+1)'(neg && wrap); // [R2] [R27]
      per_q  <= wrap ? 8'h00 : 8'(per_q + 8'h01);      // [R27]
      tick_q <= neg || wrap;                           // [R1]
    end else begin
      cnt_q  <= cnt_q - 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign tick_o = tick_q;

endmodule // usfb_baud

//--- usfb_rxfifo.sv
`timescale 1ns/100ps
module usfb_rxfifo #(
  parameter int W     = 11,
  parameter int DEPTH = 2
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         flush_i,
  input  wire logic         push_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic         pop_i,
  output logic [W-1:0]      head_o,
  output logic              empty_o,
  output logic              full_o
);
  import usfb_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [CW-1:0] cnt_q;

  // ****************************************
  // shift entries, oldest at index 0
  // ****************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic [W-1:0] nxt;
    if (i == DEPTH - 1) begin : g_last
      assign nxt = '0;
    end else begin : g_mid
      assign nxt = mem_q[i+1];
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        mem_q[i] <= '0;
      end else if (pop_i) begin
        mem_q[i] <= (push_i && CW'(i + 1) == cnt_q) ? data_i : nxt;
      end else if (push_i && CW'(i) == cnt_q) begin
        mem_q[i] <= data_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (flush_i) begin
      cnt_q <= '0;
    end else if (push_i && !pop_i) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop_i && !push_i) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign head_o  = mem_q[0];
  assign empty_o = (cnt_q == '0);
  assign full_o  = (cnt_q == CW'(DEPTH));

endmodule // usfb_rxfifo

//--- usfb_usart.sv
// Overview of operation
// R1 - a baud tick fires at each counter zero; receiver samples line per tick; a positive exponent ticks only every 2^exponent zeros here
// R2 - fractional scale inserts an extra count periodically, stretching mean period
// R3 - normal async bits sampled sixteen times, centre three samples vote
// R4 - software keeps two to the scale under half the frame cycle count
// R5 - software enables transmitter in spi master mode, receiver when needed
// R6 - spi master mode drives transfer clock pin from the transmitter
// R7 - in spi master mode a data write starts every transfer
// R8 - spi master mode forces frame, overrun and parity error to zero
// R9 - phase and bit order controls act as on a standard spi master
// R10 - master only: serial out is mosi, serial in is miso, no select
// R11 - spi master keeps tx holding buffer, rx extra level, no collision flag
// R12 - filter frame type from first stop bit, or ninth bit if nine
// R13 - frame type one is address; filter drops data frames
// R14 - sender unaffected by filter, uses two stops for short characters
// R15 - filtering master sends nine bit characters, ninth bit marks address
// R16 - addressed slave turns filter off, back on after last data frame
// R17 - software never combines infrared mode with double speed
// R18 - tx and rx holding buffers share one address, write tx, read rx
// R19 - short characters: tx ignores upper bits, rx returns them zero
// R20 - data write while tx buffer not empty is discarded
// R21 - enabled transmitter moves buffer to empty shifter, then shifts out
// R22 - rx buffer is two deep; flags advance on each data read
// R23 - rx complete shows unread data; rx disable or one-write flushes
// R24 - tx empty flag set at reset and when empty, cleared by write
// R25 - overrun when buffer full, shifter waiting and new start detected
// R26 - double speed halves divider in async only, no effect in sync
// R27 - counter reloads from select value; exponent sets stretch frequency
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module usfb_usart (
  input  wire logic                      ref_clk_i,
  input  wire logic                      nrst_i,
  input  wire logic [usfb_pkg::ADR_W-1:0] addr_i,
  input  wire logic [7:0]                wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic [7:0]                     rdata_o,
  input  wire logic                      rxd_i,
  output logic                           txd_o,
  output logic                           txd_oe_o,
  output logic                           xck_o,
  output logic                           xck_oe_o
);
  import usfb_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0]     ctrl_q;
  logic [7:0]     frame_q;
  logic [7:0]     baud_lo_q;
  logic [7:0]     baud_hi_q;
  logic [7:0]     rdata_q;
  logic [8:0]     txb_q;
  logic           txb_full_q;
  logic           txc_q;
  logic [12:0]    tx_sh_q;
  logic [3:0]     tx_left_q;
  logic [4:0]     tx_smp_q;
  logic           tx_busy_q;
  logic           tx_ph_q;
  logic           txd_q;
  logic           txd_oe_q;
  logic           xck_q;
  logic           xck_oe_q;
  usfb_rx_state_t rx_st_q;
  logic           rx_prev_q;
  logic [4:0]     rx_smp_q;
  logic [1:0]     rx_vote_q;
  logic [3:0]     rx_cnt_q;
  logic [10:0]    rx_sh_q;
  logic [7:0]     spi_rx_q;
  logic           pend_q;
  logic [10:0]    pend_word_q;
  logic           ovf_q;
  logic           tick;
  logic [10:0]    head;
  logic           empty;
  logic           full;

  logic           spim;
  logic           dbl_eff;
  logic [4:0]     spb;
  logic [4:0]     vote_at;
  logic [3:0]     nd;
  logic           par_en;
  logic           par_odd;
  logic           cpha;
  logic           lsbf;
  logic           rx_en;
  logic           tx_en;
  logic           filter;
  logic [7:0]     mask8;
  logic [3:0]     tx_total;
  logic [3:0]     rx_total;
  logic           wr_data;
  logic           wr_status;
  logic           rd_data;
  logic           tx_go;
  logic           tx_done;
  logic           spi_samp;
  logic           spi_last;
  logic [7:0]     spi_rx_d;
  logic [7:0]     spi_rx_n;
  logic [12:0]    tx_fr;
  logic [8:0]     tx_dat;
  logic [4:0]     smp_nx;
  logic           vote_now;
  logic           vbit;
  logic           start_seen;
  logic [10:0]    rx_sh_n;
  logic           a_done;
  logic [8:0]     a_dat;
  logic           a_stop;
  logic           a_parity_error_flag;
  logic           accept;
  logic           got_ok;
  logic [10:0]    got_word;
  logic           flush;
  logic           pop;
  logic           push;
  logic [10:0]    push_word;

  // ****************************************
  // configuration decode
  // ****************************************
  assign spim     = (frame_q[7:6] == MODE_SPIM);
  assign dbl_eff  = ctrl_q[CT_DBL] && (frame_q[7:6] != MODE_SYNC) && !spim; // [R26]
  assign spb      = dbl_eff ? SPB_DOUBLE : SPB_NORMAL;                    // [R3] [R26]
  assign vote_at  = dbl_eff ? VOTE_DOUBLE : VOTE_NORMAL;                  // [R3]
  assign nd       = usfb_nbits(frame_q[2:0]);
  assign par_en   = frame_q[FR_PEN];
  assign par_odd  = frame_q[FR_PODD];
  assign cpha     = frame_q[FR_PHASE];
  assign lsbf     = frame_q[FR_ORDER];
  assign rx_en    = ctrl_q[CT_RXEN];
  assign tx_en    = ctrl_q[CT_TXEN];
  assign filter   = ctrl_q[CT_FILTER] && !spim;
  assign mask8    = (nd >= 4'h8) ? 8'hFF : 8'(8'hFF >> 4'(4'h8 - nd));
  assign tx_total = 4'(4'h2 + nd + {3'h0, par_en} + {3'h0, frame_q[FR_STOP2]});
  assign rx_total = 4'(nd + {3'h0, par_en} + 4'h1);

  assign wr_data   = wr_i && (addr_i == ADR_DATA);
  assign wr_status = wr_i && (addr_i == ADR_STATUS);
  assign rd_data   = rd_i && (addr_i == ADR_DATA);

  // ****************************************
  // baud generator and receive buffer
  // ****************************************
  usfb_baud #(
    .BW (12)
  ) u_baud (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .baud_select_value_i    ({baud_hi_q[3:0], baud_lo_q}),
    .baud_scale_exponent_i  (baud_hi_q[7:4]),
    .tick_o    (tick)
  );

  usfb_rxfifo #(
    .W     (11),
    .DEPTH (2)
  ) u_fifo (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .flush_i   (flush),
    .push_i    (push),
    .data_i    (push_word),
    .pop_i     (pop),
    .head_o    (head),
    .empty_o   (empty),
    .full_o    (full)
  );

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q    <= CTRL_RST;
      frame_q   <= FRAME_RST;
      baud_lo_q <= BAUD_RST;
      baud_hi_q <= BAUD_RST;
    end else if (wr_i) begin
      case (addr_i)
        ADR_CTRL:    ctrl_q    <= wdata_i;
        ADR_FRAME:   frame_q   <= wdata_i;
        ADR_BAUD_LO: baud_lo_q <= wdata_i;
        ADR_BAUD_HI: baud_hi_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // ****************************************
  // transmit buffer and flags
  // ****************************************
  assign tx_go   = txb_full_q && tx_en && !tx_busy_q;                      // [R21]
  assign tx_done = tx_busy_q && tick && (tx_left_q == 4'h1) &&
                   (spim ? tx_ph_q : (tx_smp_q == 5'(spb - 5'h01)));

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txb_q      <= 9'h000;
      txb_full_q <= 1'b0;                                                 // [R24]
    end else if (tx_go) begin
      txb_full_q <= 1'b0;                                                 // [R24]
    end else if (wr_data && !txb_full_q) begin                           // [R20] [R7]
      txb_q      <= {ctrl_q[CT_TX9], wdata_i & (spim ? 8'hFF : mask8)};   // [R19] [R18]
      txb_full_q <= 1'b1;                                                 // [R24] [R11]
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txc_q <= 1'b0;
    end else if (tx_done && !txb_full_q) begin
      txc_q <= 1'b1;
    end else if (wr_status && wdata_i[ST_TXC]) begin
      txc_q <= 1'b0;
    end
  end

  // ****************************************
  // transmit frame build
  // ****************************************
  always_comb begin
    tx_dat = {(nd == 4'h9) && txb_q[8], txb_q[7:0]};
    tx_fr  = '1;
    tx_fr[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nd) begin
        tx_fr[i+1] = tx_dat[i];
      end
    end
    if (par_en) begin
      tx_fr[4'(nd + 4'h1)] = ^tx_dat ^ par_odd;
    end
  end

  // ****************************************
  // transmit shifter and transfer clock
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_sh_q   <= '1;
      tx_left_q <= 4'h0;
      tx_smp_q  <= 5'h00;
      tx_busy_q <= 1'b0;
      tx_ph_q   <= 1'b0;
      txd_q     <= 1'b1;
      xck_q     <= 1'b0;
    end else if (tx_go) begin                                             // [R21]
      tx_busy_q <= 1'b1;
      tx_smp_q  <= 5'h00;
      tx_ph_q   <= 1'b0;
      xck_q     <= 1'b0;
      if (spim) begin
        tx_sh_q   <= {5'h1F, lsbf ? txb_q[7:0] : {<<{txb_q[7:0]}}};       // [R9]
        tx_left_q <= SPI_BITS;
        txd_q     <= lsbf ? txb_q[0] : txb_q[7];                          // [R10]
      end else begin
        tx_sh_q   <= tx_fr;
        tx_left_q <= tx_total;
        txd_q     <= 1'b0;
      end
    end else if (tx_busy_q && tick) begin
      if (spim) begin
        tx_ph_q <= ~tx_ph_q;
        xck_q   <= ~tx_ph_q;                                              // [R6]
        if (!tx_ph_q && cpha) begin
          txd_q <= tx_sh_q[0];                                            // [R9]
        end
        if (tx_ph_q) begin
          tx_sh_q   <= {1'b1, tx_sh_q[12:1]};
          tx_left_q <= tx_left_q - 4'h1;
          if (!cpha) begin
            txd_q <= tx_sh_q[1];                                          // [R9]
          end
          if (tx_left_q == 4'h1) begin
            tx_busy_q <= 1'b0;
          end
        end
      end else if (tx_smp_q == 5'(spb - 5'h01)) begin
        tx_smp_q  <= 5'h00;
        tx_sh_q   <= {1'b1, tx_sh_q[12:1]};
        tx_left_q <= tx_left_q - 4'h1;
        txd_q     <= tx_sh_q[1];                                          // [R21]
        if (tx_left_q == 4'h1) begin
          tx_busy_q <= 1'b0;
          txd_q     <= 1'b1;
        end
      end else begin
        tx_smp_q <= tx_smp_q + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txd_oe_q <= 1'b0;
      xck_oe_q <= 1'b0;
    end else begin
      txd_oe_q <= tx_en || tx_busy_q || txb_full_q;
      xck_oe_q <= spim;                                                   // [R6]
    end
  end

  // ****************************************
  // spi receive path
  // ****************************************
  assign spi_samp = spim && tx_busy_q && tick && (cpha ? tx_ph_q : !tx_ph_q); // [R9]
  assign spi_last = spim && tx_done;
  assign spi_rx_d = lsbf ? {rxd_i, spi_rx_q[7:1]} : {spi_rx_q[6:0], rxd_i};     // [R10]
  assign spi_rx_n = spi_samp ? spi_rx_d : spi_rx_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spi_rx_q <= 8'h00;
    end else if (spi_samp) begin
      spi_rx_q <= spi_rx_d;
    end
  end

  // ****************************************
  // async receiver
  // ****************************************
  assign smp_nx     = (rx_smp_q == spb) ? 5'h01 : 5'(rx_smp_q + 5'h01);
  assign vote_now   = (smp_nx == vote_at);
  assign vbit       = (rx_vote_q[1] & rx_vote_q[0]) | (rx_vote_q[1] & rxd_i) |
                      (rx_vote_q[0] & rxd_i);                             // [R3]
  assign start_seen = tick && rx_en && !spim && (rx_st_q == RX_IDLE) &&
                      rx_prev_q && !rxd_i;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st_q   <= RX_IDLE;
      rx_prev_q <= 1'b1;
      rx_smp_q  <= 5'h00;
      rx_vote_q <= 2'h3;
      rx_cnt_q  <= 4'h0;
      rx_sh_q   <= 11'h000;
    end else if (!rx_en || spim) begin
      rx_st_q   <= RX_IDLE;
      rx_prev_q <= 1'b1;
    end else if (tick) begin                                              // [R1]
      rx_prev_q <= rxd_i;
      rx_vote_q <= {rx_vote_q[0], rxd_i};
      rx_smp_q  <= smp_nx;
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_prev_q && !rxd_i) begin
            rx_st_q  <= RX_START;
            rx_smp_q <= 5'h01;
            rx_cnt_q <= 4'h0;
          end
        end
        RX_START: begin
          if (vote_now) begin
            rx_st_q <= vbit ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (vote_now) begin
            rx_sh_q  <= rx_sh_n;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == 4'(rx_total - 4'h1)) begin
              rx_st_q <= RX_IDLE;
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  always_comb begin
    rx_sh_n = rx_sh_q;
    rx_sh_n[rx_cnt_q] = vbit;
  end

  assign a_done = tick && rx_en && !spim && (rx_st_q == RX_DATA) && vote_now &&
                  (rx_cnt_q == 4'(rx_total - 4'h1));
  assign a_dat  = {(nd == 4'h9) && rx_sh_n[8], rx_sh_n[7:0] & mask8};   // [R19]
  assign a_stop = rx_sh_n[4'(nd + {3'h0, par_en})];
  assign a_parity_error_flag = par_en && (^a_dat ^ rx_sh_n[nd] ^ par_odd);
  assign accept = !filter || ((nd == 4'h9) ? a_dat[8] : a_stop);         // [R12] [R13]

  assign got_ok   = (a_done && accept) || (spi_last && rx_en);
  assign got_word = spim ? {3'h0, spi_rx_n} : {a_parity_error_flag, !a_stop, a_dat};  // [R8]

  // ****************************************
  // receive buffering and overrun
  // ****************************************
  assign flush     = !rx_en || (wr_status && wdata_i[ST_RXC]);           // [R23]
  assign pop       = rd_data && !empty;                                   // [R22]
  assign push      = !flush && (pend_q ? !full : (got_ok && !full));     // [R11]
  assign push_word = pend_q ? pend_word_q : got_word;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_q      <= 1'b0;
      pend_word_q <= 11'h000;
    end else if (flush) begin
      pend_q      <= got_ok;
      pend_word_q <= got_word;
    end else if (pend_q && !full) begin
      pend_q      <= got_ok;
      pend_word_q <= got_word;
    end else if (got_ok && full) begin
      pend_q      <= 1'b1;
      pend_word_q <= got_word;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovf_q <= 1'b0;
    end else if (start_seen && full && pend_q) begin
      ovf_q <= 1'b1;                                                      // [R25]
    end else if (flush || pop) begin
      ovf_q <= 1'b0;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADR_DATA:    rdata_q <= (empty || !rx_en) ? 8'h00 : head[7:0];    // [R18] [R23]
        ADR_STATUS:  rdata_q <= {!empty && rx_en, txc_q, !txb_full_q,     // [R23] [R24]
                                 head[9] && !empty && rx_en && !spim,     // [R8]
                                 ovf_q && !spim,                          // [R8]
                                 head[10] && !empty && rx_en && !spim,    // [R8]
                                 1'b0,
                                 head[8] && !empty && rx_en && !spim};    // [R22]
        ADR_CTRL:    rdata_q <= ctrl_q;
        ADR_FRAME:   rdata_q <= frame_q;
        ADR_BAUD_LO: rdata_q <= baud_lo_q;
        ADR_BAUD_HI: rdata_q <= baud_hi_q;
        default:     rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o  = rdata_q;
  assign txd_o    = txd_q;
  assign txd_oe_o = txd_oe_q;
  assign xck_o    = xck_q;
  assign xck_oe_o = xck_oe_q;

endmodule // usfb_usart

//--- usfb_usart_props.sv
`timescale 1ns/100ps
module usfb_usart_props
  import usfb_pkg::*;
(
  input wire logic             ref_clk_i,
  input wire logic             nrst_i,
  input wire logic [ADR_W-1:0] addr_i,
  input wire logic [7:0]       wdata_i,
  input wire logic             wr_i,
  input wire logic             rd_i,
  input wire logic [7:0]       rdata_o,
  input wire logic             txd_o,
  input wire logic             txd_oe_o,
  input wire logic             xck_o,
  input wire logic             xck_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_RD_SLOT: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its slot");
  AST_UNMAPPED: assert property (rd_i && addr_i > ADR_BAUD_HI |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_RSVD: assert property (rd_i && addr_i == ADR_STATUS |=> !rdata_o[1])
    else $error("reserved status bit set");
  AST_SPI_ERR: assert property (rd_i && addr_i == ADR_STATUS && xck_oe_o |=> rdata_o[4:2] == 3'h0)
    else $error("error flags set in spi mode");
  AST_XCK_IDLE: assert property (!xck_oe_o |-> !xck_o)
    else $error("transfer clock outside spi mode");
  AST_TXD_IDLE: assert property (!txd_oe_o |-> txd_o)
    else $error("serial out low while released");
  AST_SPI_GO: assert property (wr_i && addr_i == ADR_DATA && xck_oe_o && txd_oe_o
    |-> ##[1:100] xck_o)
    else $error("data write started no transfer");
  AST_RX_OFF: assert property (wr_i && addr_i == ADR_CTRL && !wdata_i[CT_RXEN]
    ##1 rd_i && addr_i == ADR_STATUS |=> !rdata_o[ST_RXC])
    else $error("rx complete after receiver off");
  AST_RST_OUT: assert property ($rose(nrst_i) |-> txd_o && !txd_oe_o && !xck_oe_o)
    else $error("outputs wrong after reset");
endmodule // usfb_usart_props
bind usfb_usart usfb_usart_props u_props (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .txd_o(txd_o), .txd_oe_o(txd_oe_o), .xck_o(xck_o), .xck_oe_o(xck_oe_o));

//--- usfb_spi_slave.sv
`timescale 1ns/100ps
module usfb_spi_slave (
  input  wire logic sck_i,
  input  wire logic mosi_i,
  output logic      miso_o
);
  logic [7:0] sh = 8'hA5;
  logic       bit_q = 1'b0;
  // sample on rising clock, shift reply on falling, msb first
  always @(posedge sck_i) bit_q <= mosi_i;
  always @(negedge sck_i) sh <= {sh[6:0], bit_q};
  assign miso_o = sh[7];
endmodule // usfb_spi_slave

//--- usfb_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  import usfb_pkg::*;
  logic       ref_clk_i, nrst_i, wr_i, rd_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  wire        rxd_i, txd_o, txd_oe_o, xck_o, xck_oe_o;
  int         miscompares = 0;
  int         tests_run = 0;
  usfb_usart uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .txd_oe_o(txd_oe_o), .xck_o(xck_o), .xck_oe_o(xck_oe_o));
  wire        miso;
  assign rxd_i = xck_oe_o ? miso : txd_o;
  usfb_spi_slave slave (.sck_i(xck_o), .mosi_i(txd_o), .miso_o(miso));
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
  endtask
  task automatic idle();
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    idle();
    #1 `CHK(rdata_o, e)
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_txc();
    logic done;
    done = 1'b0;
    for (int i = 0; i < 200 && !done; i++) begin
      acc(1'b0, ADR_STATUS, 8'h00);
      idle();
      #1 done = (rdata_o[ST_TXC] === 1'b1);
    end
    if (!done) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic t_reset();
    rchk(ADR_STATUS, STATUS_RST);
    rchk(3'h7, 8'h00);
    rchk(ADR_DATA, 8'h00);
  endtask
  task automatic t_spi();
    acc(1'b1, ADR_FRAME, 8'hC0);
    acc(1'b1, ADR_BAUD_LO, 8'h02);
    acc(1'b1, ADR_CTRL, 8'h18);
    acc(1'b1, ADR_DATA, 8'h3C);
    acc(1'b1, ADR_DATA, 8'h77);
    idle();
    acc(1'b1, ADR_DATA, 8'h0F);
    acc(1'b1, ADR_DATA, 8'hFF);
    idle();
    wait_txc();
    rchk(ADR_STATUS, 8'hE0);
    rchk(ADR_DATA, 8'hA5);
    rchk(ADR_STATUS, 8'hE0);
    acc(1'b1, ADR_CTRL, 8'h08);
    acc(1'b0, ADR_STATUS, 8'h00);
    idle();
    #1 `CHK(rdata_o, 8'h60)
    `CHK(slave.sh, 8'h0F)
  endtask
  task automatic t_lsb();
    acc(1'b1, ADR_STATUS, 8'h40);
    acc(1'b1, ADR_CTRL, 8'h18);
    acc(1'b1, ADR_FRAME, 8'hC4);
    acc(1'b1, ADR_DATA, 8'h01);
    idle();
    wait_txc();
    `CHK(slave.sh, 8'h80)
    rchk(ADR_DATA, 8'hF0);
  endtask
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    acc(1'b1, ADR_STATUS, 8'h40);
    acc(1'b1, ADR_CTRL, c);
    acc(1'b1, ADR_DATA, d);
    idle();
    wait_txc();
  endtask
  task automatic t_address_filter_mode();
    acc(1'b1, ADR_CTRL, 8'h00);
    acc(1'b1, ADR_FRAME, 8'h07);
    acc(1'b1, ADR_BAUD_LO, 8'h00);
    send(8'h1A, 8'h5A);
    send(8'h1B, 8'hA3);
    send(8'h18, 8'h11);
    rchk(ADR_STATUS, 8'hE1);
    rchk(ADR_DATA, 8'hA3);
    rchk(ADR_STATUS, 8'hE0);
    rchk(ADR_DATA, 8'h11);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    nrst_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_spi();
    t_lsb();
    t_address_filter_mode();
    wrap_up();
  end
endmodule // testbench
